// *** hw/owtf_fifo.v ***
// Word FIFO with registered read data and valid/ready on both sides
module owtf_fifo #(
  parameter WIDTH = 40,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             clk_sys,
  input  wire             rst_b,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data,
  output wire [AW:0]      level
);

  reg [WIDTH-1:0] mem_ff [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_ff;
  reg [AW-1:0]    rd_ptr_ff;
  reg [AW:0]      cnt_ff;
  reg             ov_ff;
  reg [WIDTH-1:0] od_ff;

  wire push;
  wire load;

  assign in_ready  = (cnt_ff != DEPTH[AW:0]);
  assign push      = in_valid & in_ready;
  // Refill the output register whenever it is empty or being drained
  assign load      = (cnt_ff != {(AW+1){1'b0}}) & (~ov_ff | out_ready);
  assign out_valid = ov_ff;
  assign out_data  = od_ff;
  assign level     = cnt_ff;

  always @(posedge clk_sys) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_data;
    end
  end

  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr_ff <= {AW{1'b0}};
      rd_ptr_ff <= {AW{1'b0}};
      cnt_ff    <= {(AW+1){1'b0}};
      ov_ff     <= 1'b0;
      od_ff     <= {WIDTH{1'b0}};
    end else begin
      if (push) begin
        wr_ptr_ff <= (wr_ptr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_ff + 1'b1;
      end
      if (load) begin
        od_ff     <= mem_ff[rd_ptr_ff];
        ov_ff     <= 1'b1;
        rd_ptr_ff <= (rd_ptr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_ff + 1'b1;
      end else if (out_ready) begin
        ov_ff <= 1'b0;
      end
      if (push & ~load) begin
        cnt_ff <= cnt_ff + 1'b1;
      end else if (load & ~push) begin
        cnt_ff <= cnt_ff - 1'b1;
      end
    end
  end

endmodule // owtf_fifo

// *** hw/owtf_framer.v ***
// Overhead word framer: builds word-two and access global action words, serialises them
`include "owtf_regs.vh"
module owtf_framer #(
  parameter                   FIFO_DEPTH = 8,
  parameter                   FIFO_AW    = 3,
  parameter [`OWTF_PAR_W-1:0] PAR_POLY   = 12'h80f
) (
  input  wire       clk_sys,
  input  wire       rst_b,
  input  wire       msg_req_valid,
  output wire       msg_req_ready,
  input  wire       msg_select,
  input  wire [1:0] word_type_code,
  input  wire [1:0] color_code,
  input  wire       serial_word_flag,
  input  wire       extended_addr_flag,
  input  wire       home_registration_flag,
  input  wire       roam_registration_flag,
  input  wire [1:0] discontinuous_tx_field,
  input  wire [5:0] paging_channel_count,
  input  wire       read_control_filler_flag,
  input  wire       combined_paging_access_flag,
  input  wire [7:0] access_channel_count,
  input  wire       last_word_flag,
  input  wire [3:0] global_action_code,
  input  wire       busy_idle_flag,
  input  wire [14:0] access_reserved_bits,
  input  wire       clear_count_error,
  output wire       tx_bit,
  output wire       tx_bit_valid,
  input  wire       tx_bit_ready,
  output wire       tx_word_start,
  output wire       tx_word_end,
  output wire       count_error,
  output wire [15:0] words_sent,
  output wire       frame_busy,
  output wire [FIFO_AW:0] fifo_level
);

  localparam ST_IDLE  = 1'b0;
  localparam ST_SHIFT = 1'b1;
  localparam [5:0] LAST_BIT = `OWTF_LAST_BIT;

  reg                      stage_vld_ff;
  reg [`OWTF_INFO_W-1:0]   stage_info_ff;
  reg                      count_error_ff;
  reg                      state_ff;
  reg [`OWTF_WORD_W-1:0]   shift_ff;
  reg [5:0]                bit_cnt_ff;
  reg [15:0]               words_sent_ff;
  reg                      word_start_ff;
  reg                      word_end_ff;

  reg                      nxt_stage_vld;
  reg [`OWTF_INFO_W-1:0]   nxt_stage_info;
  reg                      nxt_count_error;
  reg                      nxt_state;
  reg [`OWTF_WORD_W-1:0]   nxt_shift;
  reg [5:0]                nxt_bit_cnt;
  reg [15:0]               nxt_words_sent;
  reg                      nxt_word_start;
  reg                      nxt_word_end;

  reg [`OWTF_INFO_W-1:0]   word2_info;
  reg [`OWTF_INFO_W-1:0]   access_info;
  reg [`OWTF_INFO_W-1:0]   built_info;
  reg                      range_fault;
  reg [7:0]                page_m1;
  reg [7:0]                access_m1;
  reg                      page_bad;
  reg                      access_bad;

  wire                     req_take;
  wire [`OWTF_PAR_W-1:0]   parity;
  wire                     fifo_in_ready;
  wire                     fifo_out_valid;
  wire                     fifo_out_ready;
  wire [`OWTF_WORD_W-1:0]  fifo_out_data;
  wire                     bit_take;

  // Count minus one, saturating: zero maps to zero, above max maps to max field value
  function [7:0] owtf_minus_one;
    input [7:0] count;
    input [7:0] max;
    begin
      if (count == 8'h00) begin
        owtf_minus_one = 8'h00;
      end else if (count > max) begin
        owtf_minus_one = max - 8'h01;
      end else begin
        owtf_minus_one = count - 8'h01;
      end
    end
  endfunction

  function owtf_out_of_range;
    input [7:0] count;
    input [7:0] max;
    begin
      owtf_out_of_range = (count == 8'h00) || (count > max);
    end
  endfunction

  // One-deep staging register feeds the parity divider; it stalls on a full FIFO
  assign msg_req_ready = ~stage_vld_ff | fifo_in_ready;
  assign req_take      = msg_req_valid & msg_req_ready;

  // Count fields and their range checks, shared by the packer and the error flag
  always @* begin
    page_m1    = owtf_minus_one({2'h0, paging_channel_count}, {2'h0, `OWTF_PAGE_MAX}); // R7
    access_m1  = owtf_minus_one(access_channel_count, `OWTF_ACCESS_MAX); // R8
    page_bad   = owtf_out_of_range({2'h0, paging_channel_count}, {2'h0, `OWTF_PAGE_MAX});
    access_bad = owtf_out_of_range(access_channel_count, `OWTF_ACCESS_MAX);
  end

  // System parameter word two, packed MSB first
  always @* begin
    word2_info                         = {`OWTF_INFO_W{1'b0}};
    word2_info[`OWTF_POS_TYPE +: 2]    = word_type_code; // R1
    word2_info[`OWTF_POS_COLOR +: 2]   = color_code; // R2
    word2_info[`OWTF_POS_SERIAL]       = serial_word_flag; // R3
    word2_info[`OWTF_POS_EXT]          = extended_addr_flag; // R4
    word2_info[`OWTF_POS_HOME_REGISTRATION_FLAG]         = home_registration_flag; // R5
    word2_info[`OWTF_POS_ROAM_REGISTRATION_FLAG]         = roam_registration_flag; // R6
    word2_info[`OWTF_POS_DTX +: 2]     = discontinuous_tx_field; // R14
    word2_info[`OWTF_POS_PAGE +: 5]    = page_m1[4:0]; // R7
    word2_info[`OWTF_POS_RCF]          = read_control_filler_flag; // R14
    word2_info[`OWTF_POS_CPA]          = combined_paging_access_flag; // R14
    word2_info[`OWTF_POS_ACCESS +: 7]  = access_m1[6:0]; // R8
    word2_info[`OWTF_POS_END]          = last_word_flag; // R9
    word2_info[`OWTF_POS_OHD +: 3]     = `OWTF_OHD_WORD2; // R10
  end

  // Counts mean nothing in the access word, so they are neither packed nor checked there
  always @* begin
    access_info                        = {`OWTF_INFO_W{1'b0}};
    access_info[`OWTF_POS_TYPE +: 2]   = word_type_code; // R1
    access_info[`OWTF_POS_COLOR +: 2]  = color_code; // R2
    access_info[`OWTF_POS_ACT +: 4]    = global_action_code; // R12
    access_info[`OWTF_POS_BIS]         = busy_idle_flag;
    access_info[`OWTF_POS_RSVD +: 15]  = access_reserved_bits;
    access_info[`OWTF_POS_END]         = last_word_flag; // R9
    access_info[`OWTF_POS_OHD +: 3]    = `OWTF_OHD_GLOBAL; // R10
  end

  always @* begin
    built_info  = {`OWTF_INFO_W{1'b0}};
    range_fault = 1'b0;
    case (msg_select)
      `OWTF_SEL_WORD2: begin
        built_info  = word2_info;
        range_fault = page_bad | access_bad; // R7 R8
      end
      `OWTF_SEL_ACCESS: begin
        built_info  = access_info;
      end
      default: begin
        built_info  = {`OWTF_INFO_W{1'b0}};
      end
    endcase
  end

  always @* begin
    nxt_stage_vld  = stage_vld_ff;
    nxt_stage_info = stage_info_ff;
    if (req_take) begin
      nxt_stage_vld  = 1'b1;
      nxt_stage_info = built_info;
    end else if (fifo_in_ready) begin
      nxt_stage_vld  = 1'b0;
    end
  end

  // A fault seen in the clear cycle still sets the flag
  always @* begin
    nxt_count_error = count_error_ff;
    if (clear_count_error) begin
      nxt_count_error = 1'b0;
    end
    if (req_take && range_fault) begin
      nxt_count_error = 1'b1;
    end
  end

  owtf_parity #(
    .POLY   (PAR_POLY)
  ) u_parity (
    .info   (stage_info_ff),
    .parity (parity)
  );

  owtf_fifo #(
    .WIDTH     (`OWTF_WORD_W),
    .DEPTH     (FIFO_DEPTH),
    .AW        (FIFO_AW)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .rst_b     (rst_b),
    .in_valid  (stage_vld_ff),
    .in_ready  (fifo_in_ready),
    .in_data   ({stage_info_ff, parity}), // R14
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data),
    .level     (fifo_level)
  );

  // Serialiser: MSB first, one bit per accepted handshake
  assign fifo_out_ready = (state_ff == ST_IDLE);
  assign bit_take       = (state_ff == ST_SHIFT) & tx_bit_ready;

  always @* begin
    nxt_state   = state_ff;
    nxt_shift   = shift_ff;
    nxt_bit_cnt = bit_cnt_ff;
    case (state_ff)
      ST_IDLE: begin
        if (fifo_out_valid) begin
          nxt_state   = ST_SHIFT;
          nxt_shift   = fifo_out_data;
          nxt_bit_cnt = 6'h00;
        end
      end
      ST_SHIFT: begin
        if (bit_take) begin
          nxt_shift   = {shift_ff[`OWTF_WORD_W-2:0], 1'b0};
          nxt_bit_cnt = bit_cnt_ff + 6'h01;
          if (bit_cnt_ff == LAST_BIT) begin
            nxt_state   = ST_IDLE;
            nxt_bit_cnt = 6'h00;
          end
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // Word markers are registered from the next state so they line up with tx_bit
  always @* begin
    nxt_word_start = (nxt_state == ST_SHIFT) & (nxt_bit_cnt == 6'h00);
    nxt_word_end   = (nxt_state == ST_SHIFT) & (nxt_bit_cnt == LAST_BIT);
  end

  // Sent-word count advances as the last parity bit is taken and wraps silently
  always @* begin
    nxt_words_sent = words_sent_ff;
    if (bit_take && (bit_cnt_ff == LAST_BIT)) begin
      nxt_words_sent = words_sent_ff + 16'h0001;
    end
  end

  // The stage holds one built word while the FIFO is full
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      stage_vld_ff   <= 1'b0;
      stage_info_ff  <= {`OWTF_INFO_W{1'b0}};
    end else begin
      stage_vld_ff   <= nxt_stage_vld;
      stage_info_ff  <= nxt_stage_info;
    end
  end

  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      count_error_ff <= 1'b0;
    end else begin
      count_error_ff <= nxt_count_error;
    end
  end

  // Serialiser registers; an asynchronous reset drops a word mid-shift
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_ff       <= ST_IDLE;
      shift_ff       <= {`OWTF_WORD_W{1'b0}};
      bit_cnt_ff     <= 6'h00;
      word_start_ff  <= 1'b0;
      word_end_ff    <= 1'b0;
    end else begin
      state_ff       <= nxt_state;
      shift_ff       <= nxt_shift;
      bit_cnt_ff     <= nxt_bit_cnt;
      word_start_ff  <= nxt_word_start;
      word_end_ff    <= nxt_word_end;
    end
  end

  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      words_sent_ff  <= 16'h0000;
    end else begin
      words_sent_ff  <= nxt_words_sent;
    end
  end

  assign tx_bit        = shift_ff[`OWTF_WORD_W-1];
  assign tx_bit_valid  = (state_ff == ST_SHIFT);
  assign tx_word_start = word_start_ff;
  assign tx_word_end   = word_end_ff;
  assign count_error   = count_error_ff;
  assign words_sent    = words_sent_ff;
  assign frame_busy    = stage_vld_ff | fifo_out_valid | (state_ff == ST_SHIFT) |
                         (fifo_level != {(FIFO_AW+1){1'b0}});

endmodule // owtf_framer

// *** hw/owtf_parity.v ***
// Parity generator: remainder of the info bits divided by the generator polynomial
`include "owtf_regs.vh"
module owtf_parity #(
  parameter [`OWTF_PAR_W-1:0] POLY = 12'h80f
) (
  input  wire [`OWTF_INFO_W-1:0] info,
  output wire [`OWTF_PAR_W-1:0]  parity
);

  function [`OWTF_PAR_W-1:0] owtf_divide;
    input [`OWTF_INFO_W-1:0] data;
    reg   [`OWTF_PAR_W-1:0]  rem;
    reg                      fb;
    integer                  i;
    begin
      rem = {`OWTF_PAR_W{1'b0}};
      for (i = `OWTF_INFO_W - 1; i >= 0; i = i - 1) begin
        fb  = data[i] ^ rem[`OWTF_PAR_W-1];
        rem = {rem[`OWTF_PAR_W-2:0], 1'b0} ^ (fb ? POLY : {`OWTF_PAR_W{1'b0}});
      end
      owtf_divide = rem;
    end
  endfunction

  // Parity depends only on the assembled fields
  assign parity = owtf_divide(info); // R11

endmodule // owtf_parity

// *** hw/owtf_regs.vh ***
// Field layout, type codes and limits for the overhead word framer
//
// Summary of operation
// R1 - Each word carries a 2-bit word type code taken from the operator input.
// R2 - Each word carries a 2-bit color code taken from the operator input.
// R3 - The serial word flag bit is 1 when the serial number word is sent and 0 when not.
// R4 - The extended address flag bit is 1 when the extended address word is sent and 0 when not.
// R5 - A one-bit home registration flag is carried for mobiles in their home system.
// R6 - A separate one-bit roam registration flag is carried for roaming mobiles.
// R7 - The paging channel count goes out as a 5-bit field holding the count minus one.
// R8 - The access channel count goes out as a 7-bit field holding the count minus one.
// R9 - The last word flag is 1 on the final word of the overhead train and 0 on earlier words.
// R10 - The 3-bit overhead type is 100 for global action, 110 for word one, 111 for word two.
// R11 - The framer computes the parity bits itself; the operator has no way to supply them.
// R12 - The access-type global action word carries a 4-bit action code after type and color.
// R13 - The operator supplies the last word flag as exactly one binary character.
// R14 - Fields are packed MSB first in the documented order, parity last.
`ifndef OWTF_REGS_VH
`define OWTF_REGS_VH

`define OWTF_INFO_W      28
`define OWTF_PAR_W       12
`define OWTF_WORD_W      40
`define OWTF_LAST_BIT    6'h27

// Word two field positions (lsb of each field within the 28 info bits)
`define OWTF_POS_TYPE    26
`define OWTF_POS_COLOR   24
`define OWTF_POS_SERIAL  23
`define OWTF_POS_EXT     22
`define OWTF_POS_HOME_REGISTRATION_FLAG    21
`define OWTF_POS_ROAM_REGISTRATION_FLAG    20
`define OWTF_POS_DTX     18
`define OWTF_POS_PAGE    13
`define OWTF_POS_RCF     12
`define OWTF_POS_CPA     11
`define OWTF_POS_ACCESS  4
`define OWTF_POS_END     3
`define OWTF_POS_OHD     0

// Access global action field positions
`define OWTF_POS_ACT     20
`define OWTF_POS_BIS     19
`define OWTF_POS_RSVD    4

// Overhead type codes
`define OWTF_OHD_GLOBAL  3'h4
`define OWTF_OHD_WORD1   3'h6
`define OWTF_OHD_WORD2   3'h7

// Channel count limits (counts are 1-based on the ports)
`define OWTF_PAGE_MAX    6'h20
`define OWTF_ACCESS_MAX  8'h80

// Message selectors
`define OWTF_SEL_WORD2   1'b0
`define OWTF_SEL_ACCESS  1'b1

`endif

// *** testbench/owtf_framer_bench.sv ***
// Self-checking bench for the overhead word framer
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin miscompares++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
module owtf_framer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam [11:0] POLY = 12'h80f;
  logic        clk_sys, rst_b, msg_req_valid, msg_select, clear_count_error, hold, slow;
  logic        serial_word_flag, extended_addr_flag, home_registration_flag, last_word_flag;
  logic        roam_registration_flag, read_control_filler_flag, combined_paging_access_flag;
  logic        busy_idle_flag;
  logic [1:0]  word_type_code, color_code, discontinuous_tx_field;
  logic [3:0]  global_action_code;
  logic [5:0]  paging_channel_count;
  logic [7:0]  access_channel_count;
  logic [14:0] access_reserved_bits;
  wire         msg_req_ready, tx_bit, tx_bit_valid, tx_bit_ready, tx_word_start;
  wire         tx_word_end, count_error, frame_busy, got;
  wire  [15:0] words_sent;
  wire  [3:0]  fifo_level;
  wire  [39:0] got_word;
  logic [39:0] q[$];
  logic [39:0] ex;
  integer      miscompares = 0, n_tests = 0, k, j;
  // Row: expected count error, select, paging count, access count, remaining fields
  logic [48:0] rows [9] = '{
    {1'b0, 1'b0, 6'h01, 8'h01, 33'h1_a5c3_3c5a}, {1'b0, 1'b0, 6'h20, 8'h80, 33'h0_5a3c_c3a5},
    {1'b0, 1'b0, 6'h17, 8'h26, 33'h1_ffff_0000}, {1'b0, 1'b1, 6'h00, 8'h00, 33'h0_96e1_7ff5},
    {1'b0, 1'b1, 6'h3f, 8'hff, 33'h1_0f0f_8001}, {1'b1, 1'b0, 6'h00, 8'h40, 33'h0_0000_ffff},
    {1'b1, 1'b0, 6'h21, 8'h40, 33'h1_3333_cccc}, {1'b1, 1'b0, 6'h05, 8'h00, 33'h0_c0de_1234},
    {1'b1, 1'b0, 6'h05, 8'h81, 33'h1_7777_8888}};
  owtf_framer #(.PAR_POLY(POLY)) i_owtf_framer (
    .clk_sys(clk_sys), .rst_b(rst_b), .msg_req_valid(msg_req_valid),
    .msg_req_ready(msg_req_ready), .msg_select(msg_select), .word_type_code(word_type_code),
    .color_code(color_code), .serial_word_flag(serial_word_flag),
    .extended_addr_flag(extended_addr_flag), .home_registration_flag(home_registration_flag),
    .roam_registration_flag(roam_registration_flag),
    .discontinuous_tx_field(discontinuous_tx_field), .paging_channel_count(paging_channel_count),
    .read_control_filler_flag(read_control_filler_flag),
    .combined_paging_access_flag(combined_paging_access_flag),
    .access_channel_count(access_channel_count), .last_word_flag(last_word_flag),
    .global_action_code(global_action_code), .busy_idle_flag(busy_idle_flag),
    .access_reserved_bits(access_reserved_bits), .clear_count_error(clear_count_error),
    .tx_bit(tx_bit), .tx_bit_valid(tx_bit_valid), .tx_bit_ready(tx_bit_ready),
    .tx_word_start(tx_word_start), .tx_word_end(tx_word_end), .count_error(count_error),
    .words_sent(words_sent), .frame_busy(frame_busy), .fifo_level(fifo_level));
  owtf_sink i_owtf_sink (
    .clk_sys(clk_sys), .rst_b(rst_b), .tx_bit(tx_bit), .tx_bit_valid(tx_bit_valid),
    .tx_word_end(tx_word_end), .hold(hold), .slow(slow), .tx_bit_ready(tx_bit_ready),
    .done(got), .word(got_word));
  function [11:0] par(input [27:0] d);
    integer i;
    begin
      par = 12'h000;
      for (i = 27; i >= 0; i--) par = {par[10:0], 1'b0} ^ ((d[i] ^ par[11]) ? POLY : 12'h000);
    end
  endfunction
  // Out-of-range counts saturate to the nearest legal field value
  function [7:0] sat(input [7:0] c, input [7:0] m);
    sat = c == 8'h00 ? 8'h00 : c > m ? m - 8'h01 : c - 8'h01;
  endfunction
  function [39:0] expw();
    logic [7:0]  tp, ta;
    logic [27:0] i;
    begin
      tp = sat({2'h0, paging_channel_count}, 8'h20);
      ta = sat(access_channel_count, 8'h80);
      i = msg_select ? {word_type_code, color_code, global_action_code, busy_idle_flag,
            access_reserved_bits, last_word_flag, 3'h4} :
          {word_type_code, color_code, serial_word_flag, extended_addr_flag,
            home_registration_flag, roam_registration_flag, discontinuous_tx_field, tp[4:0],
            read_control_filler_flag, combined_paging_access_flag, ta[6:0], last_word_flag,
            3'h7};
      expw = {i, par(i)};
    end
  endfunction
  task give_verdict;
    begin
      if (miscompares == 0 && n_tests > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
    end
  endtask
  task tmo;
    begin
      miscompares++;
      give_verdict;
    end
  endtask
  task tick;
    begin
      @(posedge clk_sys);
      #1;
    end
  endtask
  // Leaves the request raised so callers can issue back to back
  task send(input [47:0] r);
    begin
      {msg_select, paging_channel_count, access_channel_count, word_type_code, color_code,
       serial_word_flag, extended_addr_flag, home_registration_flag, roam_registration_flag,
       discontinuous_tx_field, read_control_filler_flag, combined_paging_access_flag,
       last_word_flag, global_action_code, busy_idle_flag, access_reserved_bits} = r;
      msg_req_valid = 1'b1;
      q.push_back(expw());
      for (j = 0; msg_req_ready !== 1'b1; j++) begin
        if (j > 4000) tmo;
        tick;
      end
      tick;
    end
  endtask
  task drain;
    begin
      for (j = 0; frame_busy !== 1'b0 || q.size() != 0; j++) begin
        if (j > 9000) tmo;
        tick;
      end
      `CHK(fifo_level, 4'h0)
    end
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (got === 1'b1) begin
      ex = q.size() ? q.pop_front() : 40'h0;
      `CHK(got_word, ex)
    end
  end
  initial begin
    {rst_b, msg_req_valid, clear_count_error, hold, slow} = 5'h00;
    send_init: {msg_select, paging_channel_count, access_channel_count, word_type_code,
      color_code, serial_word_flag, extended_addr_flag, home_registration_flag,
      roam_registration_flag, discontinuous_tx_field, read_control_filler_flag,
      combined_paging_access_flag, last_word_flag, global_action_code, busy_idle_flag,
      access_reserved_bits} = 48'h0;
    repeat (16) tick;
    `CHK({msg_req_ready, tx_bit_valid, count_error, frame_busy}, 4'h8)
    `CHK({words_sent, fifo_level}, 20'h00000)
    rst_b = 1'b1;
    slow = 1'b1;
    for (k = 0; k < 9; k++) begin
      clear_count_error = 1'b1;
      tick;
      clear_count_error = 1'b0;
      send(rows[k][47:0]);
      msg_req_valid = 1'b0;
      repeat (2) tick;
      `CHK(count_error, rows[k][48])
    end
    // Clear and fault in one cycle: the fault wins, then a lone clear works
    clear_count_error = 1'b1;
    send(rows[5][47:0]);
    {msg_req_valid, clear_count_error} = 2'b00;
    `CHK(count_error, 1'b1)
    clear_count_error = 1'b1;
    tick;
    clear_count_error = 1'b0;
    `CHK(count_error, 1'b0)
    drain;
    slow = 1'b0;
    hold = 1'b1;
    for (k = 0; k < 11; k++) send(rows[k % 5][47:0]);
    msg_req_valid = 1'b0;
    repeat (6) tick;
    `CHK({msg_req_ready, fifo_level}, 5'h08)
    hold = 1'b0;
    drain;
    `CHK(words_sent, 16'h0015)
    // Reset in the middle of a word must drop it and leave the pipe usable
    send(rows[2][47:0]);
    msg_req_valid = 1'b0;
    repeat (12) tick;
    rst_b = 1'b0;
    tick;
    q.delete();
    `CHK({tx_bit_valid, frame_busy, words_sent}, 18'h00000)
    rst_b = 1'b1;
    send(rows[3][47:0]);
    msg_req_valid = 1'b0;
    drain;
    `CHK(words_sent, 16'h0001)
    give_verdict;
  end
endmodule // owtf_framer_bench

// *** testbench/owtf_framer_props.sv ***
// Checker for the framer request and serial ports
module owtf_framer_props (
  input wire        clk_sys,
  input wire        rst_b,
  input wire        msg_req_valid,
  input wire        msg_req_ready,
  input wire        msg_select,
  input wire [5:0]  paging_channel_count,
  input wire [7:0]  access_channel_count,
  input wire        clear_count_error,
  input wire        tx_bit,
  input wire        tx_bit_valid,
  input wire        tx_bit_ready,
  input wire        tx_word_start,
  input wire        tx_word_end,
  input wire        count_error,
  input wire [15:0] words_sent,
  input wire        frame_busy
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0]  cnt_ff;
  logic [38:0] sh_ff;
  wire         take = tx_bit_valid && tx_bit_ready;
  wire         req = msg_req_valid && msg_req_ready;
  wire         bad = paging_channel_count == 6'h00 || paging_channel_count > 6'h20 ||
                     access_channel_count == 8'h00 || access_channel_count > 8'h80;
  // Bit position inside the word, counted only on taken bits
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cnt_ff <= 6'h00;
      sh_ff  <= 39'h0;
    end else if (take) begin
      cnt_ff <= tx_word_end ? 6'h00 : cnt_ff + 6'h01;
      sh_ff  <= {sh_ff[37:0], tx_bit};
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  property p_len; tx_bit_valid |-> tx_word_end == (cnt_ff == 6'h27); endproperty
  a_len: assert property (p_len) else $error("word end flag off position");
  property p_start; tx_bit_valid |-> tx_word_start == (cnt_ff == 6'h00); endproperty
  a_start: assert property (p_start) else $error("word start flag off position");
  property p_hold; tx_bit_valid && !tx_bit_ready |=> tx_bit_valid && $stable(tx_bit); endproperty
  a_hold: assert property (p_hold) else $error("serial bit changed while stalled");
  property p_gap; take && tx_word_end |=> !tx_bit_valid; endproperty
  a_gap: assert property (p_gap) else $error("no idle cycle after word");
  // Only word two and global action are built, so type bits 1:0 are 11 or 00
  property p_type; take && tx_word_end |-> sh_ff[13] && sh_ff[12] == sh_ff[11]; endproperty
  a_type: assert property (p_type) else $error("bad overhead type code");
  property p_lat; req && !frame_busy |-> ##4 tx_word_start; endproperty
  a_lat: assert property (p_lat) else $error("first bit not offered in time");
  property p_err; req && !msg_select && bad |-> ##[1:2] count_error; endproperty
  a_err: assert property (p_err) else $error("count error not flagged");
  property p_sticky; count_error && !clear_count_error |=> count_error; endproperty
  a_sticky: assert property (p_sticky) else $error("count error lost");
  property p_sent; take && tx_word_end |=> words_sent == $past(words_sent) + 16'h0001; endproperty
  a_sent: assert property (p_sent) else $error("sent word count wrong");
  c_stall: cover property (tx_bit_valid && !tx_bit_ready);
  c_full: cover property (!msg_req_ready);
  c_err: cover property ($rose(count_error));
endmodule // owtf_framer_props

bind owtf_framer owtf_framer_props i_owtf_framer_props (
  .clk_sys(clk_sys), .rst_b(rst_b), .msg_req_valid(msg_req_valid),
  .msg_req_ready(msg_req_ready), .msg_select(msg_select),
  .paging_channel_count(paging_channel_count), .access_channel_count(access_channel_count),
  .clear_count_error(clear_count_error), .tx_bit(tx_bit), .tx_bit_valid(tx_bit_valid),
  .tx_bit_ready(tx_bit_ready), .tx_word_start(tx_word_start), .tx_word_end(tx_word_end),
  .count_error(count_error), .words_sent(words_sent), .frame_busy(frame_busy));

// *** testbench/owtf_sink.sv ***
// Serial sink for the mobile side, with stall and half-rate modes
module owtf_sink (
  input  wire         clk_sys,
  input  wire         rst_b,
  input  wire         tx_bit,
  input  wire         tx_bit_valid,
  input  wire         tx_word_end,
  input  wire         hold,
  input  wire         slow,
  output wire         tx_bit_ready,
  output logic        done,
  output logic [39:0] word
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        tgl_ff;
  logic [38:0] sh_ff;
  // Half rate stalls on every other cycle from a free-running toggle, whatever the bit position, which exercises the hold path
  assign tx_bit_ready = !hold && (!slow || tgl_ff);
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      tgl_ff <= 1'b0;
      sh_ff  <= 39'h0;
      done   <= 1'b0;
      word   <= 40'h0;
    end else begin
      tgl_ff <= !tgl_ff;
      done   <= tx_bit_valid && tx_bit_ready && tx_word_end;
      if (tx_bit_valid && tx_bit_ready) begin
        sh_ff <= {sh_ff[37:0], tx_bit};
        if (tx_word_end) word <= {sh_ff, tx_bit};
      end
    end
  end
endmodule // owtf_sink
